// >>> logic/egc_defines.vh
/*
 * constants for the encrypted guest entry check block: control block
 * offsets and bit positions, feature leaf bits, register map of the
 * block's own port, exit codes and reset values.
 * assumes plain verilog-2005 and one include per file.
 */
`ifndef EGC_DEFINES_VH
`define EGC_DEFINES_VH

// control block layout
`define EGC_CB_ADDRESS_SPACE_ID_OFS 12'h058
`define EGC_CB_CTL_OFS 12'h090
`define EGC_CB_NP_BIT 0
`define EGC_CB_EG_BIT 1
// feature leaf bits
`define EGC_FEAT_HME_BIT 0
`define EGC_FEAT_EG_BIT 1
`define EGC_FEAT_LM64_BIT 11
// hardware config register lock bit
`define EGC_HARDWARE_CONFIG_MSR_LOCK_BIT 0
// register port map
`define EGC_REG_STATUS 4'h0
`define EGC_REG_MASK 4'h1
`define EGC_REG_STATE 4'h2
`define EGC_REG_FEAT 4'h3
`define EGC_REG_KEYINFO 4'h4
`define EGC_REG_CFG 4'h5
// status bits
`define EGC_ST_ENTRY_OK 0
`define EGC_ST_ENTRY_FAIL 1
`define EGC_ST_PAGE_FAULT 2
// exit codes
`define EGC_EXIT_NONE 8'h00
`define EGC_EXIT_INVALID 8'hff
// reset values
`define EGC_MASK_RST 32'h0000_0000
`define EGC_CFG_RST 32'h0000_0000
`endif

// >>> logic/egc_key_select.v
/*
 * per access key and encryption decision for a running guest.
 * assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/10ps
module egc_key_select #(
	parameter ADDRESS_SPACE_ID_W = 10,
	parameter PA_W = 52
) (
	input wire clk, // core clock
	input wire rst_b, // sync reset, active low
	input wire acc_valid, // access request
	input wire [PA_W-1:0] acc_addr, // system physical address
	input wire acc_fetch, // instruction fetch
	input wire acc_walk, // guest page table walk
	input wire acc_cbit, // guest page table c-bit
	input wire acc_host_cbit, // nested table c-bit
	input wire guest_mode, // core is in guest mode
	input wire eg_active, // encrypted guest running
	input wire guest_ctl_mode, // long or extended address mode
	input wire [ADDRESS_SPACE_ID_W-1:0] address_space_id, // running guest id
	input wire [PA_W-1:0] rsvd_mask, // bits lost to size reduction
	output reg out_valid, // decision valid
	output reg out_encrypt, // access is encrypted
	output reg out_guest_key, // guest key, else host key
	output reg [ADDRESS_SPACE_ID_W-1:0] out_key_index, // key slot index
	output reg out_fault // reserved address bit fault
);
	reg priv;
	reg enc;
	reg gkey;

	// decision for one access
	always @* begin
		priv = 1'b0;
		enc = 1'b0;
		gkey = 1'b0;
		if (guest_mode && eg_active) begin
			// no guest choice outside long modes
			priv = acc_fetch || acc_walk || !guest_ctl_mode || acc_cbit;
			enc = priv || acc_host_cbit;
			gkey = priv;
		end else begin
			enc = guest_mode ? acc_host_cbit : acc_cbit;
		end
	end

	// registered outputs; key index only ever names a slot, never a key
	always @(posedge clk) begin
		if (!rst_b) begin
			out_valid <= 1'b0;
			out_encrypt <= 1'b0;
			out_guest_key <= 1'b0;
			out_key_index <= {ADDRESS_SPACE_ID_W{1'b0}};
			out_fault <= 1'b0;
		end else begin
			out_valid <= acc_valid;
			out_fault <= acc_valid && |(acc_addr & rsvd_mask);
			out_encrypt <= acc_valid && enc;
			out_guest_key <= acc_valid && gkey;
			out_key_index <= (acc_valid && gkey) ? address_space_id : {ADDRESS_SPACE_ID_W{1'b0}};
		end
	end
endmodule // egc_key_select

// >>> logic/egc_entry_check.v
/*
 * encrypted guest entry check: validates the enable conditions when the
 * guest entry instruction runs, keeps the running guest's encryption
 * state, drives the per access key selection and holds a small register
 * file with sticky events, mask and interrupt.
 * assumes the hypervisor side hands over control block words and mode
 * levels on the core clock, and that keys are loaded elsewhere by the
 * security processor; this block only sees key slot indices.
 */
`timescale 1ns/10ps
`include "egc_defines.vh"
module egc_entry_check #(
	parameter ADDRESS_SPACE_ID_W = 10,
	parameter PA_W = 52,
	parameter KEY_CNT = 16,
	parameter CBIT_POS = 47,
	parameter PA_REDUCE = 5
) (
	input wire clk, // core clock
	input wire rst_b, // sync reset, active low
	input wire entry_req, // guest entry instruction, pulse
	input wire [31:0] cb_ctl, // control block word at 090h
	input wire [31:0] cb_address_space_id, // control block word at 058h
	input wire memory_encryption_mode_enable, // system config level
	input wire smm_config_lock, // hardware config lock level
	input wire host_64bit, // hypervisor in 64-bit mode
	input wire guest_exit, // guest left, pulse
	input wire guest_ctl_mode, // guest in long or extended address mode
	input wire acc_valid, // memory access request
	input wire [PA_W-1:0] acc_addr, // access physical address
	input wire acc_fetch, // access is instruction fetch
	input wire acc_walk, // access is guest table walk
	input wire acc_cbit, // guest table c-bit
	input wire acc_host_cbit, // nested table c-bit
	input wire [3:0] reg_addr, // register index
	input wire [31:0] reg_wdata, // register write data
	input wire reg_wr, // register write strobe
	input wire reg_rd, // register read strobe
	output reg [31:0] reg_rdata, // read data, one cycle later
	output reg entry_done, // entry decided, pulse
	output reg entry_started, // guest started, pulse
	output reg [7:0] exit_code, // entry exit code
	output reg guest_mode, // guest running
	output reg eg_active, // guest runs encrypted
	output wire acc_out_valid, // access decision valid
	output wire acc_encrypt, // access encrypted
	output wire acc_guest_key, // access uses guest key
	output wire [ADDRESS_SPACE_ID_W-1:0] acc_key_index, // key slot index
	output wire acc_fault, // reserved bit page fault
	output wire irq // level interrupt
);
	localparam ST_IDLE = 2'd0;
	localparam ST_CHECK = 2'd1;
	localparam ST_RUN = 2'd2;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [31:0] ctl_reg;
	reg [ADDRESS_SPACE_ID_W-1:0] address_space_id_reg;
	reg [31:0] status_reg;
	reg [31:0] mask_reg;
	reg [31:0] cfg_reg;
	reg want_eg;
	reg chk_fail;
	reg [ADDRESS_SPACE_ID_W:0] address_space_id_max;
	wire [PA_W-1:0] rsvd_mask;
	wire lm64_req;
	wire [31:0] feat_word;
	wire [31:0] keyinfo_word;
	wire ev_ok;
	wire ev_fail;
	wire [31:0] ev_set;

	// capability words; key count is the top encryption capable id
	assign lm64_req = cfg_reg[0];
	assign feat_word = (32'h0000_0001 << `EGC_FEAT_HME_BIT) |
		(32'h0000_0001 << `EGC_FEAT_EG_BIT) |
		({31'h0000_0000, lm64_req} << `EGC_FEAT_LM64_BIT);
	assign keyinfo_word = {10'h000, PA_REDUCE[5:0], KEY_CNT[9:0],
		CBIT_POS[5:0]};

	// reduced size address bits are the top PA_REDUCE bits of the space, only while encryption mode is enabled
	genvar gi;
	generate
		for (gi = 0; gi < PA_W; gi = gi + 1) begin : g_rsvd
			assign rsvd_mask[gi] = (gi >= PA_W - PA_REDUCE) &&
				memory_encryption_mode_enable;
		end
	endgenerate

	// enable conditions and checks, from the latched control words
	always @* begin
		address_space_id_max = KEY_CNT[ADDRESS_SPACE_ID_W:0];
		want_eg = memory_encryption_mode_enable &&
			ctl_reg[`EGC_CB_EG_BIT];
		chk_fail = 1'b0;
		if (want_eg) begin
			if (!ctl_reg[`EGC_CB_NP_BIT])
				chk_fail = 1'b1;
			if (!smm_config_lock)
				chk_fail = 1'b1;
			if (address_space_id_reg == {ADDRESS_SPACE_ID_W{1'b0}} ||
				{1'b0, address_space_id_reg} > address_space_id_max)
				chk_fail = 1'b1;
			if (lm64_req && !host_64bit)
				chk_fail = 1'b1;
		end
	end

	// entry sequencer
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (entry_req)
				state_next = ST_CHECK;
		end
		ST_CHECK: begin
			state_next = chk_fail ? ST_IDLE : ST_RUN;
		end
		ST_RUN: begin
			if (guest_exit)
				state_next = ST_IDLE;
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
	end

	// latch control words at entry so a later change cannot slip past
	always @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			ctl_reg <= 32'h0000_0000;
			address_space_id_reg <= {ADDRESS_SPACE_ID_W{1'b0}};
			entry_done <= 1'b0;
			entry_started <= 1'b0;
			exit_code <= `EGC_EXIT_NONE;
			guest_mode <= 1'b0;
			eg_active <= 1'b0;
		end else begin
			state_reg <= state_next;
			entry_done <= 1'b0;
			entry_started <= 1'b0;
			if (state_reg == ST_IDLE && entry_req) begin
				ctl_reg <= cb_ctl;
				address_space_id_reg <= cb_address_space_id[ADDRESS_SPACE_ID_W-1:0];
			end
			if (state_reg == ST_CHECK) begin
				entry_done <= 1'b1;
				if (chk_fail) begin
					exit_code <= `EGC_EXIT_INVALID;
				end else begin
					exit_code <= `EGC_EXIT_NONE;
					entry_started <= 1'b1;
					guest_mode <= 1'b1;
					eg_active <= want_eg;
				end
			end
			if (state_reg == ST_RUN && guest_exit) begin
				guest_mode <= 1'b0;
				eg_active <= 1'b0;
			end
		end
	end

	egc_key_select #(
		.ADDRESS_SPACE_ID_W(ADDRESS_SPACE_ID_W),
		.PA_W(PA_W)
	) u_key_select (
		.clk(clk),
		.rst_b(rst_b),
		.acc_valid(acc_valid),
		.acc_addr(acc_addr),
		.acc_fetch(acc_fetch),
		.acc_walk(acc_walk),
		.acc_cbit(acc_cbit),
		.acc_host_cbit(acc_host_cbit),
		.guest_mode(guest_mode),
		.eg_active(eg_active),
		.guest_ctl_mode(guest_ctl_mode),
		.address_space_id(address_space_id_reg),
		.rsvd_mask(rsvd_mask),
		.out_valid(acc_out_valid),
		.out_encrypt(acc_encrypt),
		.out_guest_key(acc_guest_key),
		.out_key_index(acc_key_index),
		.out_fault(acc_fault)
	);

	// events; a set in the cycle of a clear wins
	assign ev_ok = state_reg == ST_CHECK && !chk_fail;
	assign ev_fail = state_reg == ST_CHECK && chk_fail;
	assign ev_set = ({31'h0000_0000, ev_ok} << `EGC_ST_ENTRY_OK) |
		({31'h0000_0000, ev_fail} << `EGC_ST_ENTRY_FAIL) |
		({31'h0000_0000, acc_fault} << `EGC_ST_PAGE_FAULT);
	assign irq = |(status_reg & mask_reg);

	// register writes
	always @(posedge clk) begin
		if (!rst_b) begin
			status_reg <= 32'h0000_0000;
			mask_reg <= `EGC_MASK_RST;
			cfg_reg <= `EGC_CFG_RST;
		end else begin
			if (reg_wr && reg_addr == `EGC_REG_STATUS)
				status_reg <= (status_reg & ~reg_wdata) | ev_set;
			else
				status_reg <= status_reg | ev_set;
			if (reg_wr && reg_addr == `EGC_REG_MASK)
				mask_reg <= reg_wdata & 32'h0000_0007;
			if (reg_wr && reg_addr == `EGC_REG_CFG)
				cfg_reg <= reg_wdata & 32'h0000_0001;
		end
	end

	// register reads, data in the next cycle only; unmapped reads zero
	always @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
			`EGC_REG_STATUS: reg_rdata <= status_reg;
			`EGC_REG_MASK: reg_rdata <= mask_reg;
			`EGC_REG_STATE: reg_rdata <= {16'h0000,
				address_space_id_reg[5:0], eg_active, guest_mode,
				exit_code};
			`EGC_REG_FEAT: reg_rdata <= feat_word;
			`EGC_REG_KEYINFO: reg_rdata <= keyinfo_word;
			`EGC_REG_CFG: reg_rdata <= cfg_reg;
			default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule // egc_entry_check

// >>> sim/egc_monitor.sv
/*
 * checker for the encrypted guest entry block: entry outcome and the
 * per access key decision.
 * assumes it is bound to egc_entry_check and sees only its ports.
 */
`timescale 1ns/10ps
module egc_monitor #(
	parameter PA_W = 52,
	parameter PA_REDUCE = 5
) (
	input wire clk, // clock
	input wire rst_b, // reset, low
	input wire entry_req, // entry pulse
	input wire [31:0] cb_ctl, // control word
	input wire memory_encryption_mode_enable, // global enable
	input wire smm_config_lock, // lock
	input wire guest_ctl_mode, // guest mode kind
	input wire acc_fetch, // fetch
	input wire acc_walk, // walk
	input wire [PA_W-1:0] acc_addr, // address
	input wire entry_done, // decided
	input wire entry_started, // started
	input wire [7:0] exit_code, // exit code
	input wire eg_active, // encrypted guest
	input wire acc_out_valid, // decision valid
	input wire acc_encrypt, // encrypted
	input wire acc_guest_key, // guest key
	input wire acc_fault // page fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// the global enable, nested paging and config lock checks are judged at the start of an encrypted guest
	sequence s_eg_start;
		$rose(eg_active) ##0 entry_started;
	endsequence
	done_after_req_a: assert property (entry_done |-> $past(entry_req, 2))
		else $error("entry decided without request");
	start_code_a: assert property (entry_started |-> entry_done && exit_code == 8'h00)
		else $error("started guest without clean code");
	fail_code_a: assert property (entry_done && !entry_started |-> exit_code == 8'hff)
		else $error("failed entry without invalid code");
	global_off_a: assert property (s_eg_start |-> $past(memory_encryption_mode_enable))
		else $error("encrypted guest with global enable off");
	nested_paging_a: assert property (s_eg_start |-> $past(cb_ctl[0], 2))
		else $error("encrypted guest without nested paging");
	config_lock_a: assert property (s_eg_start |-> $past(smm_config_lock))
		else $error("encrypted guest without config lock");
	private_fetch_a: assert property (acc_out_valid && $past(eg_active && (acc_fetch || acc_walk)) |-> acc_encrypt && acc_guest_key)
		else $error("fetch or walk not private");
	forced_private_a: assert property (acc_out_valid && $past(eg_active && !guest_ctl_mode) |-> acc_guest_key)
		else $error("guest key not forced");
	addr_fault_a: assert property (acc_out_valid |-> acc_fault == $past(memory_encryption_mode_enable && |acc_addr[PA_W-1:PA_W-PA_REDUCE]))
		else $error("reserved address fault wrong");
endmodule // egc_monitor

bind egc_entry_check egc_monitor #(.PA_W(PA_W), .PA_REDUCE(PA_REDUCE)) mon (
	.clk, .rst_b, .entry_req, .cb_ctl, .memory_encryption_mode_enable,
	.smm_config_lock, .guest_ctl_mode, .acc_fetch, .acc_walk, .acc_addr,
	.entry_done, .entry_started, .exit_code, .eg_active, .acc_out_valid,
	.acc_encrypt, .acc_guest_key, .acc_fault
);

// >>> sim/egc_entry_check_test.sv
/*
 * self-checking bench for egc_entry_check: random entries against a model.
 * assumes default parameters: 16 keys, 52 address bits, 5 reserved.
 */
`timescale 1ns/10ps
module egc_entry_check_test;
	logic clk, rst_b, entry_req, memory_encryption_mode_enable, guest_exit;
	logic smm_config_lock, host_64bit, guest_ctl_mode, acc_valid, acc_fetch;
	logic acc_walk, acc_cbit, acc_host_cbit, reg_wr, reg_rd, irq;
	logic [31:0] cb_ctl, cb_address_space_id, reg_wdata, reg_rdata;
	logic [51:0] acc_addr, a;
	logic [3:0] reg_addr;
	logic [7:0] exit_code;
	logic [9:0] acc_key_index;
	logic entry_done, entry_started, guest_mode, eg_active, acc_out_valid;
	logic acc_encrypt, acc_guest_key, acc_fault;
	bit mee, eg, np, lk, h, c64, on, bad, ea, pv;
	int n_errors = 0, check_count = 0, st = 0, address_space_id, r;
	egc_entry_check dut (
		.clk, .rst_b, .entry_req, .cb_ctl, .cb_address_space_id, .guest_exit,
		.memory_encryption_mode_enable, .smm_config_lock, .host_64bit,
		.guest_ctl_mode, .acc_valid, .acc_addr, .acc_fetch, .acc_walk,
		.acc_cbit, .acc_host_cbit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .entry_done, .entry_started, .exit_code, .guest_mode,
		.eg_active, .acc_out_valid, .acc_encrypt, .acc_guest_key,
		.acc_key_index, .acc_fault, .irq
	);
	// free running 125 MHz clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// writes leave one idle edge so the strobe is never set twice at once
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] ad, input logic [31:0] exp);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
		@(posedge clk);
	endtask
	task automatic irq_is(input logic e);
		#1;
		chk(irq, e);
		@(posedge clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hang guard, far beyond the under a thousand cycles the run needs
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
	// main sequence
	initial begin
		{rst_b, entry_req, guest_exit, memory_encryption_mode_enable} = '0;
		{smm_config_lock, host_64bit, guest_ctl_mode, acc_valid} = '0;
		{acc_fetch, acc_walk, acc_cbit, acc_host_cbit, reg_wr, reg_rd} = '0;
		{cb_ctl, cb_address_space_id, reg_wdata, acc_addr, reg_addr} = '0;
		r = $urandom(73510);
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(4'h4, 32'h0005_042f);
		rd(4'hf, 32'h0000_0000);
		for (int i = 0; i < 40; i++) begin
			mee = $urandom % 4 != 0;
			eg = $urandom % 4 != 0;
			np = $urandom % 4 != 0;
			lk = $urandom % 4 != 0;
			h = $urandom % 2;
			c64 = $urandom % 2;
			address_space_id = $urandom % 20;
			wr(4'h5, {31'h0, c64});
			rd(4'h3, {20'h0, c64, 11'h3});
			memory_encryption_mode_enable <= mee;
			smm_config_lock <= lk;
			host_64bit <= h;
			cb_ctl <= {30'h0, eg, np};
			cb_address_space_id <= address_space_id;
			entry_req <= 1'b1;
			@(posedge clk);
			entry_req <= 1'b0;
			@(posedge clk);
			#1;
			on = mee && eg;
			bad = on && (!np || !lk || address_space_id == 0 || address_space_id > 16 || (c64 && !h));
			ea = on && !bad;
			chk(entry_done, 1);
			chk(exit_code, bad ? 8'hff : 8'h00);
			chk({entry_started, eg_active}, {!bad, ea});
			chk(guest_mode, !bad);
			st |= bad ? 2 : 1;
			@(posedge clk);
			if (!bad) begin
				for (int k = 0; k < 4; k++) begin
					r = $urandom;
					a = {$urandom, $urandom};
					if (r[5]) a[51:47] = 5'h0;
					{acc_fetch, acc_walk, acc_cbit, acc_host_cbit} <= r[4:1];
					guest_ctl_mode <= r[0];
					acc_addr <= a;
					acc_valid <= 1'b1;
					@(posedge clk);
					acc_valid <= 1'b0;
					#1;
					pv = ea && (r[4] || r[3] || r[2] || !r[0]);
					chk({acc_out_valid, acc_encrypt}, {1'b1, pv || r[1]});
					chk(acc_guest_key, pv);
					chk(acc_key_index, pv ? address_space_id : 0);
					chk(acc_fault, mee && a[51:47] != 0);
					if (mee && a[51:47] != 0) st |= 4;
					@(posedge clk);
				end
				rd(4'h2, ((address_space_id % 64) << 10) | (ea << 9) | 32'h100);
				guest_exit <= 1'b1;
				@(posedge clk);
				guest_exit <= 1'b0;
				#1;
				chk({guest_mode, eg_active}, 2'b00);
				repeat (2) @(posedge clk);
				// host access: only the page table bit counts
				acc_addr <= '0;
				acc_valid <= 1'b1;
				@(posedge clk);
				acc_valid <= 1'b0;
				#1;
				chk({acc_encrypt, acc_guest_key, acc_fault}, {acc_cbit, 2'b00});
				@(posedge clk);
			end
		end
		irq_is(1'b0);
		wr(4'h1, 32'h0000_0007);
		rd(4'h1, 32'h0000_0007);
		rd(4'h0, st);
		irq_is(st != 0);
		wr(4'h0, 32'h0000_0002);
		rd(4'h0, st & 5);
		wr(4'h1, 32'h0000_0002);
		irq_is(1'b0);
		wr(4'h0, 32'h0000_0007);
		rd(4'h0, 32'h0000_0000);
		end_of_test();
	end
endmodule // egc_entry_check_test
